// ### hdl/cmp_pkg.sv
// Purpose: Shared constants for the comparator control register block.
// Assumes: Registers are 8 bits wide, one per aligned 32-bit bus word.
// Notes:   Offsets are register indices; byte address is index * 4.
package cmp_pkg;

	// Register indices
	localparam logic [15:0] IDX_CTRL0 = 16'h108c;
	localparam logic [15:0] IDX_EDGE  = 16'h108d;
	localparam logic [15:0] IDX_NEG   = 16'h108e;
	localparam logic [15:0] IDX_POS   = 16'h108f;
	localparam logic [15:0] IDX_COLL  = 16'h109f;
	localparam logic [15:0] IDX_STAT  = 16'h10a0;
	localparam logic [15:0] IDX_CLR   = 16'h10a1;
	localparam logic [15:0] IDX_IEN   = 16'h10a2;

	// Field positions
	localparam int CTRL_EN_BIT   = 7;
	localparam int CTRL_OUT_BIT  = 6;
	localparam int CTRL_POL_BIT  = 4;
	localparam int CTRL_HYS_BIT  = 1;
	localparam int CTRL_SYNC_BIT = 0;
	localparam int EDGE_RISE_BIT = 1;
	localparam int EDGE_FALL_BIT = 0;
	localparam int COLL_BIT      = 0;
	localparam int EVENT_BIT     = 0;

	// Values after reset
	localparam logic       BIT_RST = 1'h0;
	localparam logic [2:0] SEL_RST = 3'h0;

	// Source selector codes
	localparam logic [2:0] SEL_GND  = 3'h7;
	localparam logic [2:0] SEL_REF2 = 3'h6;
	localparam logic [2:0] SEL_DAC  = 3'h4;
	localparam logic [2:0] SEL_PIN0 = 3'h0;

	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	function automatic logic reg_hit(input logic [15:0] addr,
		input logic [15:0] idx);
		return addr == {idx[13:0], 2'h0};
	endfunction

endpackage

// ### hdl/cmp_result_if.sv
// Purpose: Carries the result path controls and outputs.
// Assumes: One clock domain.
// Notes:   regs side drives controls, core side returns the result.
`timescale 1ns/10ps
interface cmp_result_if;
	logic enable;
	logic invert;
	logic sync_mode;
	logic tmr_fall;
	logic raw;
	logic result;
	logic ext_out;
	modport regs (output enable, invert, sync_mode, tmr_fall, raw,
		input result, ext_out);
	modport core (input enable, invert, sync_mode, tmr_fall, raw,
		output result, ext_out);
endinterface

// ### hdl/cmp_sync2.sv
// Purpose: Two-flop synchroniser for the two pin inputs.
// Assumes: Inputs are asynchronous to aclk.
// Notes:   Only the second stage may be read by other logic.
`timescale 1ns/10ps
module cmp_sync2 (
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Data
	input  wire logic [1:0] d,
	output logic      [1:0] q
);
	logic [1:0] meta_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_q <= 2'h0;
			q      <= 2'h0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule

// ### hdl/cmp_result_path.sv
// Purpose: Result polarity, disable forcing and timer-aligned output.
// Assumes: raw and tmr_fall are already synchronised to aclk.
// Notes:   Result is registered every clock.
`timescale 1ns/10ps
module cmp_result_path (
	// Clock and reset
	input wire logic    aclk,
	input wire logic    aresetn,
	// Result path
	cmp_result_if.core  rif
);
	logic result_d;
	logic result_q;
	logic ext_q;

	// Disabled core reads 0; polarity still applies after it
	always_comb begin
		result_d = (rif.enable & rif.raw) ^ rif.invert;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			result_q <= 1'h0;
		end else begin
			result_q <= result_d;
		end
	end

	// Pin and timer copy: free running, or only on timer clock falls
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_q <= 1'h0;
		end else if (!rif.sync_mode || rif.tmr_fall) begin
			ext_q <= result_d;
		end
	end

	assign rif.result  = result_q;
	assign rif.ext_out = ext_q;

	sync_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		rif.sync_mode && !rif.tmr_fall |=> $stable(rif.ext_out))
		else $error("pin output moved without timer fall");
	async_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!rif.sync_mode |=> rif.ext_out == rif.result)
		else $error("pin output not following result");
	disabled_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!rif.enable && !rif.invert |=> !rif.result)
		else $error("disabled comparator result not 0");
	invert_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
		rif.enable && !rif.raw |=> rif.result == $past(rif.invert))
		else $error("polarity not applied to result");
endmodule

// ### hdl/cmp_control_regs.sv
// Purpose: Comparator control and status registers on AXI4-Lite.
// Assumes: Analog result and timer clock arrive as async digital pins.
// Notes:   Registers are 8 bits in the low lane of each word.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/10ps
module cmp_control_regs
	import cmp_pkg::*;
#(
	parameter logic LARGE_VARIANT = 1'h1
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Write address
	input  wire logic [15:0] awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	// Write data
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	// Write response
	output logic      [1:0]  bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// Read address
	input  wire logic [15:0] araddr,
	input  wire logic        arvalid,
	output logic             arready,
	// Read data
	output logic      [31:0] rdata,
	output logic      [1:0]  rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Analog side pins
	input  wire logic        compare_raw,
	input  wire logic        timer_one_clk,
	// Comparator controls
	output logic             comp_enable,
	output logic             hysteresis_on,
	output logic      [3:0]  neg_pin_sel,
	output logic             neg_ref_sel,
	output logic             neg_gnd_sel,
	output logic             pos_pin_sel,
	output logic             pos_dac_sel,
	output logic             pos_ref_sel,
	output logic             pos_gnd_sel,
	// Result outputs
	output logic             timer_one_out,
	output logic             pin_out,
	output logic             irq
);
	// Bus state
	logic        awready_q;
	logic        wready_q;
	logic        aw_full_q;
	logic        w_full_q;
	logic [15:0] aw_addr_q;
	logic [7:0]  w_data_q;
	logic        w_lane_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        arready_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	logic        aw_take;
	logic        w_take;
	logic        wr_go;
	logic        wr_low;
	logic        rd_take;

	// Register state
	logic        enable_q;
	logic        invert_select_q;
	logic        hysteresis_on_q;
	logic        sync_mode_q;
	logic        rise_flag_enable_q;
	logic        fall_flag_enable_q;
	logic [2:0]  inverting_source_sel_q;
	logic [2:0]  noninverting_source_sel_q;
	logic        compare_event_flag_q;
	logic        event_irq_enable_q;
	logic        irq_q;

	// Result and edges
	logic [1:0]  pins_s;
	logic        tmr_prev_q;
	logic        result_prev_q;
	logic        rise_seen;
	logic        fall_seen;
	logic        event_set;
	logic        event_clear;
	logic [7:0]  ctrl0_view;

	// Source select state
	logic [3:0]  neg_pin_sel_q;
	logic        neg_ref_sel_q;
	logic        neg_gnd_sel_q;
	logic        pos_pin_sel_q;
	logic        pos_dac_sel_q;
	logic        pos_ref_sel_q;
	logic        pos_gnd_sel_q;

	cmp_result_if rif ();

	cmp_sync2 pin_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       ({timer_one_clk, compare_raw}),
		.q       (pins_s)
	);

	cmp_result_path result_path (
		.aclk    (aclk),
		.aresetn (aresetn),
		.rif     (rif)
	);

	assign rif.enable    = enable_q;
	assign rif.invert    = invert_select_q;
	assign rif.sync_mode = sync_mode_q;
	assign rif.raw       = pins_s[0];
	assign rif.tmr_fall  = tmr_prev_q & ~pins_s[1];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tmr_prev_q <= 1'h0;
		end else begin
			tmr_prev_q <= pins_s[1];
		end
	end

	// Write channel: address and data are held independently
	assign aw_take = awvalid & awready_q;
	assign w_take  = wvalid & wready_q;
	assign wr_go   = aw_full_q & w_full_q & ~bvalid_q;
	assign wr_low  = wr_go & w_lane_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'h0;
			awready_q <= 1'h0;
			aw_addr_q <= 16'h0;
		end else begin
			aw_full_q <= aw_take | (aw_full_q & ~wr_go);
			awready_q <= ~(aw_take | (aw_full_q & ~wr_go));
			if (aw_take) begin
				aw_addr_q <= awaddr;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_full_q <= 1'h0;
			wready_q <= 1'h0;
			w_data_q <= 8'h0;
			w_lane_q <= 1'h0;
		end else begin
			w_full_q <= w_take | (w_full_q & ~wr_go);
			wready_q <= ~(w_take | (w_full_q & ~wr_go));
			if (w_take) begin
				w_data_q <= wdata[7:0];
				w_lane_q <= wstrb[0];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'h0;
			bresp_q  <= RESP_OKAY;
		end else if (wr_go) begin
			bvalid_q <= 1'h1;
			bresp_q  <= (reg_hit(aw_addr_q, IDX_CTRL0)
				|| reg_hit(aw_addr_q, IDX_EDGE)
				|| reg_hit(aw_addr_q, IDX_NEG)
				|| reg_hit(aw_addr_q, IDX_POS)
				|| reg_hit(aw_addr_q, IDX_COLL)
				|| reg_hit(aw_addr_q, IDX_STAT)
				|| reg_hit(aw_addr_q, IDX_CLR)
				|| reg_hit(aw_addr_q, IDX_IEN)) ? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid_q <= 1'h0;
		end
	end

	// Control register writes; only implemented bits are stored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			enable_q        <= BIT_RST;
			invert_select_q <= BIT_RST;
			hysteresis_on_q <= BIT_RST;
			sync_mode_q     <= BIT_RST;
		end else if (wr_low && reg_hit(aw_addr_q, IDX_CTRL0)) begin
			enable_q        <= w_data_q[CTRL_EN_BIT];
			invert_select_q <= w_data_q[CTRL_POL_BIT];
			hysteresis_on_q <= w_data_q[CTRL_HYS_BIT];
			sync_mode_q     <= w_data_q[CTRL_SYNC_BIT];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rise_flag_enable_q <= BIT_RST;
			fall_flag_enable_q <= BIT_RST;
		end else if (wr_low && reg_hit(aw_addr_q, IDX_EDGE)) begin
			rise_flag_enable_q <= w_data_q[EDGE_RISE_BIT];
			fall_flag_enable_q <= w_data_q[EDGE_FALL_BIT];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			inverting_source_sel_q    <= SEL_RST;
			noninverting_source_sel_q <= SEL_RST;
			event_irq_enable_q        <= BIT_RST;
		end else if (wr_low) begin
			if (reg_hit(aw_addr_q, IDX_NEG)) begin
				inverting_source_sel_q <= w_data_q[2:0];
			end
			if (reg_hit(aw_addr_q, IDX_POS)) begin
				noninverting_source_sel_q <= w_data_q[2:0];
			end
			if (reg_hit(aw_addr_q, IDX_IEN)) begin
				event_irq_enable_q <= w_data_q[EVENT_BIT];
			end
		end
	end

	// Edge detection on the registered result
	assign rise_seen   = rif.result & ~result_prev_q;
	assign fall_seen   = ~rif.result & result_prev_q;
	assign event_set   = (rise_seen & rise_flag_enable_q)
		| (fall_seen & fall_flag_enable_q);
	assign event_clear = wr_low & reg_hit(aw_addr_q, IDX_CLR)
		& w_data_q[EVENT_BIT];

	// Flag stays until software clears it; a new edge beats the clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			result_prev_q        <= 1'h0;
			compare_event_flag_q <= 1'h0;
		end else begin
			result_prev_q        <= rif.result;
			compare_event_flag_q <= event_set
				| (compare_event_flag_q & ~event_clear);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_q <= 1'h0;
		end else begin
			irq_q <= compare_event_flag_q & event_irq_enable_q;
		end
	end

	// Input routing; everything is cut off while disabled
	always_ff @(posedge aclk) begin
		if (!aresetn || !enable_q) begin
			neg_pin_sel_q <= 4'h0;
			neg_ref_sel_q <= 1'h0;
			neg_gnd_sel_q <= 1'h0;
			pos_pin_sel_q <= 1'h0;
			pos_dac_sel_q <= 1'h0;
			pos_ref_sel_q <= 1'h0;
			pos_gnd_sel_q <= 1'h0;
		end else begin
			neg_gnd_sel_q <= inverting_source_sel_q == SEL_GND;
			neg_ref_sel_q <= inverting_source_sel_q == SEL_REF2;
			neg_pin_sel_q <= 4'h0;
			// Small variants have no negative pins two and three
			if (!inverting_source_sel_q[2]
				&& (LARGE_VARIANT || !inverting_source_sel_q[1])) begin
				neg_pin_sel_q[inverting_source_sel_q[1:0]] <= 1'h1;
			end
			pos_gnd_sel_q <= noninverting_source_sel_q == SEL_GND;
			pos_ref_sel_q <= noninverting_source_sel_q == SEL_REF2;
			pos_dac_sel_q <= noninverting_source_sel_q == SEL_DAC;
			pos_pin_sel_q <= noninverting_source_sel_q == SEL_PIN0;
		end
	end

	// Read channel
	assign rd_take = arvalid & arready_q;

	always_comb begin
		ctrl0_view                = 8'h0;
		ctrl0_view[CTRL_EN_BIT]   = enable_q;
		ctrl0_view[CTRL_OUT_BIT]  = rif.result;
		ctrl0_view[CTRL_POL_BIT]  = invert_select_q;
		ctrl0_view[CTRL_HYS_BIT]  = hysteresis_on_q;
		ctrl0_view[CTRL_SYNC_BIT] = sync_mode_q;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'h0;
			rvalid_q  <= 1'h0;
			rdata_q   <= 32'h0;
			rresp_q   <= RESP_OKAY;
		end else begin
			arready_q <= ~(rd_take | (rvalid_q & ~rready));
			if (rd_take) begin
				rvalid_q <= 1'h1;
				rresp_q  <= RESP_OKAY;
				rdata_q  <= 32'h0;
				if (reg_hit(araddr, IDX_CTRL0)) begin
					rdata_q[7:0] <= ctrl0_view;
				end else if (reg_hit(araddr, IDX_EDGE)) begin
					rdata_q[EDGE_RISE_BIT] <= rise_flag_enable_q;
					rdata_q[EDGE_FALL_BIT] <= fall_flag_enable_q;
				end else if (reg_hit(araddr, IDX_NEG)) begin
					rdata_q[2:0] <= inverting_source_sel_q;
				end else if (reg_hit(araddr, IDX_POS)) begin
					rdata_q[2:0] <= noninverting_source_sel_q;
				end else if (reg_hit(araddr, IDX_COLL)) begin
					rdata_q[COLL_BIT] <= rif.result;
				end else if (reg_hit(araddr, IDX_STAT)) begin
					rdata_q[EVENT_BIT] <= compare_event_flag_q;
				end else if (reg_hit(araddr, IDX_IEN)) begin
					rdata_q[EVENT_BIT] <= event_irq_enable_q;
				end else if (!reg_hit(araddr, IDX_CLR)) begin
					rresp_q <= RESP_SLVERR;
				end
			end else if (rready) begin
				rvalid_q <= 1'h0;
			end
		end
	end

	// Ports
	assign awready       = awready_q;
	assign wready        = wready_q;
	assign bvalid        = bvalid_q;
	assign bresp         = bresp_q;
	assign arready       = arready_q;
	assign rvalid        = rvalid_q;
	assign rdata         = rdata_q;
	assign rresp         = rresp_q;
	assign comp_enable   = enable_q;
	assign hysteresis_on = hysteresis_on_q;
	assign neg_pin_sel   = neg_pin_sel_q;
	assign neg_ref_sel   = neg_ref_sel_q;
	assign neg_gnd_sel   = neg_gnd_sel_q;
	assign pos_pin_sel   = pos_pin_sel_q;
	assign pos_dac_sel   = pos_dac_sel_q;
	assign pos_ref_sel   = pos_ref_sel_q;
	assign pos_gnd_sel   = pos_gnd_sel_q;
	assign timer_one_out = rif.ext_out;
	assign pin_out       = rif.ext_out;
	assign irq           = irq_q;

	enable_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_low && reg_hit(aw_addr_q, IDX_CTRL0)
		|=> comp_enable == $past(w_data_q[CTRL_EN_BIT]))
		else $error("enable bit not stored");
	hyst_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_low && reg_hit(aw_addr_q, IDX_CTRL0)
		|=> hysteresis_on == $past(w_data_q[CTRL_HYS_BIT]))
		else $error("hysteresis bit not stored");
	rise_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
		rise_seen && rise_flag_enable_q |=> compare_event_flag_q)
		else $error("rising edge did not set flag");
	fall_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
		fall_seen && fall_flag_enable_q |=> compare_event_flag_q)
		else $error("falling edge did not set flag");
	no_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!compare_event_flag_q && !(rise_seen && rise_flag_enable_q)
		&& !(fall_seen && fall_flag_enable_q) |=> !compare_event_flag_q)
		else $error("flag set without enabled edge");
	neg_ground_a: assert property (@(posedge aclk) disable iff (!aresetn)
		enable_q && inverting_source_sel_q == SEL_GND
		|=> neg_gnd_sel && neg_pin_sel == 4'h0)
		else $error("negative ground select wrong");
	mirror_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
		rd_take && reg_hit(araddr, IDX_COLL)
		|=> rvalid && rdata[COLL_BIT] == $past(rif.result))
		else $error("collective bit not mirroring result");
	disabled_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!enable_q |=> !neg_gnd_sel && !neg_ref_sel && neg_pin_sel == 4'h0
		&& !pos_gnd_sel && !pos_ref_sel && !pos_dac_sel && !pos_pin_sel)
		else $error("input still routed while disabled");
	pol_event_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!enable_q && rise_flag_enable_q && !rif.invert
		##1 rif.invert && !enable_q
		|-> ##2 compare_event_flag_q)
		else $error("polarity toggle gave no event");
	high_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
		rvalid |-> rdata[31:8] == 24'h0)
		else $error("unused read bits not zero");
endmodule

// ### verification/cmp_control_regs_bench.sv
// Purpose: Self-checking bench for the comparator control registers.
// Assumes: Bus ready signals held high; pins are driven as plain levels.
// Notes:   Random data from an LFSR seeded at 77 mixed with corner cases.
`timescale 1ns/10ps
module cmp_control_regs_bench;
	import cmp_pkg::*;
	logic        aclk, aresetn;
	logic [15:0] awaddr, araddr;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb, neg_pin_sel;
	logic [1:0]  bresp, rresp, r;
	logic        arvalid, arready, rvalid, rready;
	logic        compare_raw, timer_one_clk, comp_enable, hysteresis_on;
	logic        neg_ref_sel, neg_gnd_sel, pos_pin_sel, pos_dac_sel;
	logic        pos_ref_sel, pos_gnd_sel, timer_one_out, pin_out, irq;
	logic [15:0] lfsr_q;
	logic [31:0] d;
	logic [7:0]  v;
	int          bad_count, samples_checked;

	cmp_control_regs uut (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.compare_raw(compare_raw), .timer_one_clk(timer_one_clk),
		.comp_enable(comp_enable), .hysteresis_on(hysteresis_on),
		.neg_pin_sel(neg_pin_sel), .neg_ref_sel(neg_ref_sel),
		.neg_gnd_sel(neg_gnd_sel), .pos_pin_sel(pos_pin_sel),
		.pos_dac_sel(pos_dac_sel), .pos_ref_sel(pos_ref_sel),
		.pos_gnd_sel(pos_gnd_sel), .timer_one_out(timer_one_out),
		.pin_out(pin_out), .irq(irq));

	always #12.5 aclk = ~aclk;

	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// Readback of control zero: result bit is computed, holes read zero
	function automatic logic [31:0] ctrl_exp(input logic [7:0] w,
		input logic raw);
		return {24'h0, w[7], (w[7] & raw) ^ w[4], 1'h0, w[4], 2'h0, w[1:0]};
	endfunction

	function automatic logic [9:0] sel_exp(input logic [2:0] n,
		input logic [2:0] p);
		logic [9:0] e;
		e = 10'h0;
		if (n < 3'h4)
			e[9:6] = 4'h1 << n;
		e[5] = (n == 3'h6);
		e[4] = (n == 3'h7);
		e[3:0] = {p == 3'h0, p == 3'h4, p == 3'h6, p == 3'h7};
		return e;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string msg);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge aclk);
	endtask

	task automatic wr(input logic [15:0] idx, input logic [7:0] dat,
		output logic [1:0] resp);
		logic aw, w;
		aw = 1'h0;
		w = 1'h0;
		awaddr <= {idx[13:0], 2'h0};
		wdata <= {24'h0, dat};
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		while (!(aw && w)) begin
			@(posedge aclk);
			if (!aw && awready) begin
				aw = 1'h1;
				awvalid <= 1'h0;
			end
			if (!w && wready) begin
				w = 1'h1;
				wvalid <= 1'h0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'h1);
		resp = bresp;
	endtask

	task automatic rd(input logic [15:0] idx, output logic [31:0] dat,
		output logic [1:0] resp);
		araddr <= {idx[13:0], 2'h0};
		arvalid <= 1'h1;
		do @(posedge aclk); while (arready !== 1'h1);
		arvalid <= 1'h0;
		do @(posedge aclk); while (rvalid !== 1'h1);
		dat = rdata;
		resp = rresp;
	endtask

	task automatic rchk(input logic [15:0] idx, input logic [31:0] exp,
		input string msg);
		rd(idx, d, r);
		chk(d, exp, msg);
		chk({30'h0, r}, {30'h0, RESP_OKAY}, "read response");
	endtask

	task automatic close_out;
		$display("checked %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		aclk = 1'h0;
		aresetn = 1'h0;
		{awaddr, araddr, wdata} = 64'h0;
		{awvalid, wvalid, arvalid} = 3'h0;
		{bready, rready} = 2'h3;
		wstrb = 4'hf;
		compare_raw = 1'h0;
		timer_one_clk = 1'h1;
		lfsr_q = 16'h004d;
		wt(2);
		aresetn <= 1'h1;
		wt(1);
		rchk(IDX_CTRL0, 32'h0, "ctrl0 reset");
		rchk(IDX_EDGE, 32'h0, "edge reset");
		rchk(IDX_NEG, 32'h0, "neg reset");
		rchk(IDX_POS, 32'h0, "pos reset");
		rchk(IDX_COLL, 32'h0, "collective reset");
		// Random control values and pin levels
		repeat (24) begin
			lfsr_q = lfsr_next(lfsr_q);
			v = lfsr_q[7:0];
			compare_raw <= lfsr_q[9];
			wr(IDX_CTRL0, v, r);
			wr(IDX_EDGE, v, r);
			wr(IDX_NEG, v, r);
			wr(IDX_POS, ~v, r);
			wt(4);
			chk({30'h0, comp_enable, hysteresis_on}, {30'h0, v[7], v[1]}, "en/hys");
			rchk(IDX_CTRL0, ctrl_exp(v, lfsr_q[9]), "ctrl0");
			rchk(IDX_COLL, {31'h0, (v[7] & lfsr_q[9]) ^ v[4]}, "coll");
			rchk(IDX_EDGE, {30'h0, v[1:0]}, "edge");
			rchk(IDX_NEG, {29'h0, v[2:0]}, "neg");
			rchk(IDX_POS, {29'h0, ~v[2:0]}, "pos");
		end
		// Collective register is read-only
		compare_raw <= 1'h0;
		wr(IDX_CTRL0, 8'h80, r);
		wr(IDX_COLL, 8'hff, r);
		wt(4);
		rchk(IDX_COLL, 32'h0, "coll write ignored");
		for (int c = 0; c < 8; c++) begin
			wr(IDX_NEG, c[7:0], r);
			wr(IDX_POS, c[7:0], r);
			wt(2);
			chk({22'h0, neg_pin_sel, neg_ref_sel, neg_gnd_sel, pos_pin_sel,
				pos_dac_sel, pos_ref_sel, pos_gnd_sel},
				{22'h0, sel_exp(c[2:0], c[2:0])}, "selectors");
		end
		wr(IDX_CTRL0, 8'h00, r);
		wt(2);
		chk({22'h0, neg_pin_sel, neg_ref_sel, neg_gnd_sel, pos_pin_sel,
			pos_dac_sel, pos_ref_sel, pos_gnd_sel}, 32'h0, "disabled sel");
		// Unmapped address
		rd(16'h1090, d, r);
		chk({d[29:0], r}, {30'h0, RESP_SLVERR}, "unmapped read");
		wr(16'h1090, 8'hff, r);
		chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write");
		// Edge events, masking and clearing
		wr(IDX_IEN, 8'h01, r);
		wr(IDX_EDGE, 8'h02, r);
		wr(IDX_CTRL0, 8'h80, r);
		wt(6);
		wr(IDX_CLR, 8'h01, r);
		compare_raw <= 1'h1;
		wt(6);
		rchk(IDX_STAT, 32'h1, "rise flag");
		chk({31'h0, irq}, 32'h1, "irq on");
		wr(IDX_CLR, 8'h01, r);
		wt(2);
		rchk(IDX_STAT, 32'h0, "flag cleared");
		chk({31'h0, irq}, 32'h0, "irq off");
		compare_raw <= 1'h0;
		wt(6);
		rchk(IDX_STAT, 32'h0, "fall blocked");
		wr(IDX_EDGE, 8'h01, r);
		compare_raw <= 1'h1;
		wt(6);
		rchk(IDX_STAT, 32'h0, "rise blocked");
		wr(IDX_IEN, 8'h00, r);
		compare_raw <= 1'h0;
		wt(6);
		rchk(IDX_STAT, 32'h1, "fall flag");
		chk({31'h0, irq}, 32'h0, "irq masked");
		// Polarity toggle while disabled
		wr(IDX_CTRL0, 8'h00, r);
		wr(IDX_EDGE, 8'h03, r);
		wt(4);
		wr(IDX_CLR, 8'h01, r);
		wr(IDX_CTRL0, 8'h10, r);
		wt(4);
		rchk(IDX_STAT, 32'h1, "polarity edge");
		rchk(IDX_CTRL0, 32'h50, "disabled inverted");
		// Timer aligned output
		wr(IDX_CTRL0, 8'h80, r);
		wt(4);
		chk({30'h0, timer_one_out, pin_out}, 32'h0, "async low");
		wr(IDX_CTRL0, 8'h81, r);
		compare_raw <= 1'h1;
		wt(8);
		chk({30'h0, timer_one_out, pin_out}, 32'h0, "sync held");
		timer_one_clk <= 1'h0;
		wt(6);
		chk({30'h0, timer_one_out, pin_out}, 32'h3, "sync update");
		timer_one_clk <= 1'h1;
		wr(IDX_CTRL0, 8'h80, r);
		compare_raw <= 1'h0;
		wt(6);
		chk({30'h0, timer_one_out, pin_out}, 32'h0, "async follow");
		close_out;
	end

	initial begin
		wt(20000);
		bad_count++;
		close_out;
	end
endmodule
